/* File: dv/fsbrq_far_agent.sv */
// Purpose: far-side bus agent issuing request phases into the block
// Assumes: lines terminated high, so a released line reads high
// Notes: caller supplies the parity wire levels, so bad parity can be sent

`timescale 1ns/1ps

module fsbrq_far_agent
  import fsbrq_pkg::*;
(
  input wire logic bus_clk, // bus clock line 0
  output logic [ADDR_W-1:0] addr_n, // address lines, wire level
  output logic [REQ_W-1:0] req_n, // request lines, wire level
  output logic vld_n, // valid strobe, wire level
  output logic [1:0] stb_n, // source strobes, wire level
  output logic [1:0] par_n // parity bits 1:0, wire level
);
  initial begin
    addr_n = '1;
    req_n = '1;
    vld_n = 1'b1;
    stb_n = 2'h3;
    par_n = 2'h3;
  end

  // ----------------------------------------
  // request issue
  // ----------------------------------------
  task automatic send(input logic [ADDR_W-1:0] a, input logic [REQ_W-1:0] t,
                      input logic [ADDR_W-1:0] at, input logic [1:0] p);
    @(posedge bus_clk);
    #2;
    vld_n = 1'b0;
    addr_n = ~a;
    req_n = ~t;
    #18 stb_n = 2'h0;
    @(posedge bus_clk);
    #2;
    vld_n = 1'b1;
    addr_n = ~at;
    par_n = p;
    #18 stb_n = 2'h3;
    @(posedge bus_clk);
    #2;
    addr_n = '1;
    req_n = '1;
    // parity held one clock longer so the receiver's late edge still sees it
    @(posedge bus_clk);
    #2;
    par_n = 2'h3;
  endtask : send
endmodule : fsbrq_far_agent

/* File: dv/fsbrq_req_phase_tb.sv */
// Purpose: self-checking bench for the request phase block
// Assumes: 200 MHz core clock, 80 ns bus clock of unrelated phase
// Notes: own drive and far agent meet on terminated wired lines

`timescale 1ns/1ps

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module fsbrq_req_phase_tb
  import fsbrq_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bclk_p = 1'b0;
  logic mask_n = 1'b1;
  logic tx_req = 1'b0;
  logic [ADDR_W-1:0] tx_addr = '0;
  logic [REQ_W-1:0] tx_type = '0;
  logic [ADDR_W-1:0] tx_attr = '0;
  logic tx_ready, addr_oe_n, vld_out_n, vld_oe_n, par0_n, par1_n, parity_oe_n;
  logic [ADDR_W-1:0] addr_out_n, addr_in_n, far_addr_n, rx_addr, rx_attr;
  logic [REQ_W-1:0] req_out_n, req_in_n, far_req_n, rx_type;
  logic [1:0] stb_out_n, stb_in_n, far_stb_n, far_par_n, par_in_n;
  logic vld_in_n, far_vld_n, rx_valid, rx_parity_err;
  int fails = 0;
  int cmp_count = 0;

  always #2.5 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #40 bclk_p = ~bclk_p;
  end

  // released drivers leave the terminated wire high
  assign addr_in_n = far_addr_n & (addr_out_n | {ADDR_W{addr_oe_n}});
  assign req_in_n = far_req_n & (req_out_n | {REQ_W{addr_oe_n}});
  assign stb_in_n = far_stb_n & (stb_out_n | {2{addr_oe_n}});
  assign vld_in_n = far_vld_n & (vld_out_n | vld_oe_n);
  assign par_in_n = far_par_n & ({par1_n, par0_n} | {2{parity_oe_n}});

  fsbrq_req_phase dut_u (
    .ref_clk, .sys_rst, .diff_bus_clock_pos(bclk_p), .diff_bus_clock_neg(~bclk_p),
    .bit_twenty_mask_in_n(mask_n), .tx_req, .tx_addr, .tx_type, .tx_attr, .tx_ready,
    .addr_out_n, .req_out_n, .addr_oe_n, .request_valid_strobe_out_n(vld_out_n),
    .request_valid_strobe_oe_n(vld_oe_n), .addr_source_sync_strobes_out_n(stb_out_n),
    .request_parity_bits_out_n_0(par0_n), .request_parity_bits_out_n_1(par1_n),
    .parity_oe_n, .addr_in_n, .req_in_n, .request_valid_strobe_in_n(vld_in_n),
    .addr_source_sync_strobes_in_n(stb_in_n), .request_parity_bits_in_n(par_in_n),
    .rx_valid, .rx_addr, .rx_attr, .rx_type, .rx_parity_err
  );

  fsbrq_far_agent far_u (
    .bus_clk(bclk_p), .addr_n(far_addr_n), .req_n(far_req_n), .vld_n(far_vld_n),
    .stb_n(far_stb_n), .par_n(far_par_n)
  );

  function automatic logic [1:0] par_wire(input logic [ADDR_W-1:0] a,
                                          input logic [REQ_W-1:0] t);
    return {~^{a[SPLIT_BIT-ADDR_LO-1:0], t}, ~^a[ADDR_W-1:SPLIT_BIT-ADDR_LO]};
  endfunction : par_wire

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic reset_case;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK("reset_oe", 3'h7, {addr_oe_n, vld_oe_n, parity_oe_n})
    `CHK("reset_idle", 2'h2, {tx_ready, rx_valid})
    $display("reset case done");
  endtask : reset_case

  task automatic tx_case(input logic [ADDR_W-1:0] a, input logic [REQ_W-1:0] t,
                         input logic [ADDR_W-1:0] at, input logic msk);
    logic [ADDR_W-1:0] ea;
    int n;
    ea = a;
    if (msk) begin
      ea[MASK_BIT-ADDR_LO] = 1'b0;
    end
    @(posedge ref_clk);
    // mask held as a steady level, as in real mode
    mask_n <= ~msk;
    // mask is asynchronous: give the synchroniser time to pass it
    repeat (6) @(posedge ref_clk);
    tx_addr <= a;
    tx_type <= t;
    tx_attr <= at;
    tx_req <= 1'b1;
    @(posedge ref_clk);
    tx_req <= 1'b0;
    for (n = 0; n < 100 && vld_out_n !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("sub1_ready", 1'b0, tx_ready)
    `CHK("sub1_addr", ~ea, addr_out_n)
    `CHK("sub1_type", ~t, req_out_n)
    `CHK("sub1_oe", 2'h0, {addr_oe_n, vld_oe_n})
    `CHK("sub1_stb", 2'h0, stb_out_n)
    for (n = 0; n < 40 && parity_oe_n !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    // one 80 ns bus clock is sixteen core cycles
    `CHK("par_delay", 16, n)
    `CHK("sub2_vld", 1'b1, vld_out_n)
    `CHK("sub2_lines", ~at, addr_out_n)
    `CHK("parity", par_wire(ea, t), {par1_n, par0_n})
    for (n = 0; n < 40 && addr_oe_n !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("release", 3'h7, {addr_oe_n, vld_oe_n, parity_oe_n})
    @(posedge ref_clk);
    #1;
    `CHK("ready_again", 1'b1, tx_ready)
    $display("tx case done, mask %0b", msk);
  endtask : tx_case

  task automatic rx_case(input logic [ADDR_W-1:0] a, input logic [REQ_W-1:0] t,
                         input logic [ADDR_W-1:0] at, input logic bad);
    int n;
    fork
      far_u.send(a, t, at, par_wire(a, t) ^ {bad, 1'b0});
    join_none
    // start looking once the far request is on the wire
    @(negedge far_vld_n);
    for (n = 0; n < 200 && rx_valid !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("rx_valid", 1'b1, rx_valid)
    `CHK("rx_addr", a, rx_addr)
    `CHK("rx_type", t, rx_type)
    `CHK("rx_attr", at, rx_attr)
    `CHK("rx_parity_err", bad, rx_parity_err)
    wait fork;
    $display("rx case done, bad parity %0b", bad);
  endtask : rx_case

  initial begin
    reset_case;
    tx_case(37'h15_a5a7_3c3c, 5'h15, 37'h0a_5a5a_c3c3, 1'b0);
    tx_case(37'h15_a5a7_3c3c, 5'h15, 37'h0a_5a5a_c3c3, 1'b1);
    tx_case(37'h1f_ffff_ffff, 5'h1f, 37'h00_0000_0000, 1'b1);
    tx_case(37'h00_0002_0000, 5'h00, 37'h1f_ffff_ffff, 1'b0);
    rx_case(37'h12_3456_789a, 5'h0b, 37'h05_a5a5_a5a5, 1'b0);
    rx_case(37'h12_3456_789a, 5'h0b, 37'h05_a5a5_a5a5, 1'b1);
    rx_case(37'h1f_ffff_ffff, 5'h1f, 37'h00_0000_0000, 1'b0);
    test_done;
  end

  initial begin
    #100000;
    fails++;
    test_done;
  end
endmodule : fsbrq_req_phase_tb

/* File: rtl/fsbrq_pkg.sv */
// Purpose: constants for the request-phase transmit/receive block
// Assumes: one 200 MHz core clock, bus clock sampled as plain inputs
// Notes: all bus pins active low on the wire

package fsbrq_pkg;
  localparam int ADDR_HI = 39;
  localparam int ADDR_LO = 3;
  localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
  localparam int REQ_W = 5;
  localparam int SPLIT_BIT = 24;
  localparam int MASK_BIT = 20;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STB_IDLE_N = 2'h3;
  typedef enum logic [2:0] {
    FSBRQ_IDLE,
    FSBRQ_SUB1,
    FSBRQ_SUB2,
    FSBRQ_PAR
  } fsbrq_state_t;
endpackage : fsbrq_pkg

/* File: rtl/fsbrq_req_phase.sv */
// Purpose: request phase sender and receiver with split parity
// Assumes: bus clock pair, strobes and pins sampled by ref_clk
// Notes: bus pin outputs change on bus clock reference edges only

`timescale 1ns/1ps

// What this block does
// - subphase one carries address, subphase two carries second subphase info on same lines; request type in both
// - parity driven one bus clock after strobe, address and request lines
// - parity high when an even number of covered lines are low
// - parity 0 covers upper address in subphase one; parity 1 covers lower address and request lines
// - valid strobe marks request; receivers begin checking on it
// - receivers capture lines on both edges of source strobe 0
// - mask input forces address bit twenty to zero before issue
// - mask input is synchronised before use
// - drive and latch on rising positive crossing falling negative clock
module fsbrq_req_phase
  import fsbrq_pkg::*;
(
  input wire logic ref_clk, // core clock 200 MHz
  input wire logic sys_rst, // sync reset, high
  input wire logic diff_bus_clock_pos, // bus clock line 0
  input wire logic diff_bus_clock_neg, // bus clock line 1
  input wire logic bit_twenty_mask_in_n, // async address mask, low active
  input wire logic tx_req, // start a request
  input wire logic [ADDR_W-1:0] tx_addr, // physical address 39:3
  input wire logic [REQ_W-1:0] tx_type, // request lines 4:0
  input wire logic [ADDR_W-1:0] tx_attr, // second subphase info
  output logic tx_ready, // idle, can take tx_req
  output logic [ADDR_W-1:0] addr_out_n, // address lines driven
  output logic [REQ_W-1:0] req_out_n, // request lines driven
  output logic addr_oe_n, // address/request enable, low drives
  output logic request_valid_strobe_out_n, // strobe drive
  output logic request_valid_strobe_oe_n, // strobe enable, low drives
  output logic [1:0] addr_source_sync_strobes_out_n, // source strobes drive
  output logic request_parity_bits_out_n_0, // parity bit 0 drive
  output logic request_parity_bits_out_n_1, // parity bit 1 drive
  output logic parity_oe_n, // parity enable, low drives
  input wire logic [ADDR_W-1:0] addr_in_n, // address lines seen
  input wire logic [REQ_W-1:0] req_in_n, // request lines seen
  input wire logic request_valid_strobe_in_n, // strobe seen
  input wire logic [1:0] addr_source_sync_strobes_in_n, // source strobes seen
  input wire logic [1:0] request_parity_bits_in_n, // parity seen
  output logic rx_valid, // one-cycle pulse, request received
  output logic [ADDR_W-1:0] rx_addr, // received address
  output logic [ADDR_W-1:0] rx_attr, // received second subphase
  output logic [REQ_W-1:0] rx_type, // received request lines
  output logic rx_parity_err // one-cycle pulse with rx_valid
);
  localparam int IN_W = ADDR_W + REQ_W + 6;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic mask_n_s;
  logic [IN_W-1:0] pins_s;
  logic bpos_s;
  logic bneg_s;

  fsbrq_sync #(.W(1), .RST_VAL(1'b1)) u_mask_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(bit_twenty_mask_in_n),
    .sync_out(mask_n_s)
  );

  // reset value matches the edge detector's idle pair, pos low and neg high
  fsbrq_sync #(.W(2), .RST_VAL(2'h1)) u_clk_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({diff_bus_clock_pos, diff_bus_clock_neg}),
    .sync_out({bpos_s, bneg_s})
  );

  fsbrq_sync #(.W(IN_W), .RST_VAL({IN_W{1'b1}})) u_pin_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({addr_in_n, req_in_n, request_valid_strobe_in_n,
               addr_source_sync_strobes_in_n, request_parity_bits_in_n, 1'b1}),
    .sync_out(pins_s)
  );

  wire [ADDR_W-1:0] a_s_n = pins_s[IN_W-1 -: ADDR_W];
  wire [REQ_W-1:0] r_s_n = pins_s[IN_W-ADDR_W-1 -: REQ_W];
  // bit 0 of the synchroniser is a spare constant, so the fields start at bit 1
  wire ads_s_n = pins_s[5];
  wire [1:0] stb_s_n = pins_s[4:3];
  wire [1:0] ap_s_n = pins_s[2:1];

  // ----------------------------------------------------------------
  // bus clock reference edge
  // ----------------------------------------------------------------
  logic bpos_ff;
  logic bneg_ff;
  logic bclk_edge;

  always_comb begin
    bclk_edge = (bpos_s & ~bneg_s) & ~(bpos_ff & ~bneg_ff);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bpos_ff <= 1'b0;
      bneg_ff <= 1'b1;
    end else begin
      bpos_ff <= bpos_s;
      bneg_ff <= bneg_s;
    end
  end

  // ----------------------------------------------------------------
  // parity helper: returns active-low wire level
  // ----------------------------------------------------------------
  // even count of low lines gives high
  function automatic logic par_n(input logic [ADDR_W+REQ_W-1:0] lines_n,
                                 input logic [ADDR_W+REQ_W-1:0] sel);
    par_n = ~(^(~lines_n & sel));
  endfunction : par_n

  localparam logic [ADDR_W+REQ_W-1:0] HI_SEL =
    {{(ADDR_HI-SPLIT_BIT+1){1'b1}}, {(SPLIT_BIT-ADDR_LO+REQ_W){1'b0}}};
  localparam logic [ADDR_W+REQ_W-1:0] LO_SEL = ~HI_SEL;

  // ----------------------------------------------------------------
  // transmit state machine
  // ----------------------------------------------------------------
  fsbrq_state_t st_ff, nxt_st;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [ADDR_W-1:0] attr_ff, nxt_attr;
  logic [REQ_W-1:0] type_ff, nxt_type;
  logic [ADDR_W-1:0] aout_ff, nxt_aout;
  logic [REQ_W-1:0] rout_ff, nxt_rout;
  logic aoe_ff, nxt_aoe;
  logic ads_ff, nxt_ads;
  logic [1:0] stb_ff, nxt_stb;
  logic [1:0] ap_ff, nxt_ap;
  logic apoe_ff, nxt_apoe;
  logic [1:0] ap_pend_ff, nxt_ap_pend;
  logic [ADDR_W-1:0] masked_addr;

  // bit twenty forced low while mask held
  always_comb begin
    masked_addr = tx_addr;
    if (!mask_n_s) begin
      masked_addr[MASK_BIT-ADDR_LO] = 1'b0;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_addr = addr_ff;
    nxt_attr = attr_ff;
    nxt_type = type_ff;
    nxt_aout = aout_ff;
    nxt_rout = rout_ff;
    nxt_aoe = aoe_ff;
    nxt_ads = ads_ff;
    nxt_stb = stb_ff;
    nxt_ap = ap_ff;
    nxt_apoe = apoe_ff;
    nxt_ap_pend = ap_pend_ff;
    unique case (st_ff)
      FSBRQ_IDLE: begin
        if (tx_req) begin
          nxt_addr = masked_addr;
          nxt_attr = tx_attr;
          nxt_type = tx_type;
          nxt_st = FSBRQ_SUB1;
        end
      end
      FSBRQ_SUB1: begin
        if (bclk_edge) begin
          nxt_aout = ~addr_ff;
          nxt_rout = ~type_ff;
          nxt_aoe = 1'b0;
          nxt_ads = 1'b0;
          nxt_stb = 2'h0;
          nxt_ap_pend[0] = par_n({~addr_ff, ~type_ff}, HI_SEL);
          nxt_ap_pend[1] = par_n({~addr_ff, ~type_ff}, LO_SEL);
          nxt_st = FSBRQ_SUB2;
        end
      end
      FSBRQ_SUB2: begin
        // second subphase on the strobe's rising edge, half clock later in
        // the real bus; here it follows the next reference edge
        if (bclk_edge) begin
          nxt_aout = ~attr_ff;
          nxt_rout = ~type_ff;
          nxt_ads = 1'b1;
          nxt_stb = STB_IDLE_N;
          // parity one bus clock after strobe
          nxt_ap = ap_pend_ff;
          nxt_apoe = 1'b0;
          nxt_st = FSBRQ_PAR;
        end
      end
      FSBRQ_PAR: begin
        if (bclk_edge) begin
          nxt_aoe = 1'b1;
          nxt_apoe = 1'b1;
          nxt_ap = 2'h3;
          nxt_st = FSBRQ_IDLE;
        end
      end
      default: nxt_st = FSBRQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= FSBRQ_IDLE;
      addr_ff <= '0;
      attr_ff <= '0;
      type_ff <= '0;
      aout_ff <= '1;
      rout_ff <= '1;
      aoe_ff <= 1'b1;
      ads_ff <= 1'b1;
      stb_ff <= STB_IDLE_N;
      ap_ff <= 2'h3;
      apoe_ff <= 1'b1;
      ap_pend_ff <= 2'h3;
    end else begin
      st_ff <= nxt_st;
      addr_ff <= nxt_addr;
      attr_ff <= nxt_attr;
      type_ff <= nxt_type;
      aout_ff <= nxt_aout;
      rout_ff <= nxt_rout;
      aoe_ff <= nxt_aoe;
      ads_ff <= nxt_ads;
      stb_ff <= nxt_stb;
      ap_ff <= nxt_ap;
      apoe_ff <= nxt_apoe;
      ap_pend_ff <= nxt_ap_pend;
    end
  end

  assign tx_ready = (st_ff == FSBRQ_IDLE);
  assign addr_out_n = aout_ff;
  assign req_out_n = rout_ff;
  assign addr_oe_n = aoe_ff;
  assign request_valid_strobe_out_n = ads_ff;
  assign request_valid_strobe_oe_n = aoe_ff;
  assign addr_source_sync_strobes_out_n = stb_ff;
  assign request_parity_bits_out_n_0 = ap_ff[0];
  assign request_parity_bits_out_n_1 = ap_ff[1];
  assign parity_oe_n = apoe_ff;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  logic [1:0] stbp_ff;
  logic [1:0] rxs_ff, nxt_rxs;
  logic [ADDR_W-1:0] raddr_ff, nxt_raddr;
  logic [ADDR_W-1:0] rattr_ff, nxt_rattr;
  logic [REQ_W-1:0] rtype_ff, nxt_rtype;
  logic rvalid_ff, nxt_rvalid;
  logic rerr_ff, nxt_rerr;
  logic [1:0] exp_ap;
  logic stb_fall;
  logic stb_rise;

  always_comb begin
    stb_fall = ~stb_s_n[0] & stbp_ff[0];
    stb_rise = stb_s_n[0] & ~stbp_ff[0];
  end

  always_comb begin
    nxt_rxs = rxs_ff;
    nxt_raddr = raddr_ff;
    nxt_rattr = rattr_ff;
    nxt_rtype = rtype_ff;
    nxt_rvalid = 1'b0;
    nxt_rerr = 1'b0;
    exp_ap[0] = par_n({~raddr_ff, ~rtype_ff}, HI_SEL);
    exp_ap[1] = par_n({~raddr_ff, ~rtype_ff}, LO_SEL);
    if (rxs_ff == 2'h0 && !ads_s_n && stb_fall) begin
      nxt_raddr = ~a_s_n;
      nxt_rtype = ~r_s_n;
      nxt_rxs = 2'h1;
    end else if (rxs_ff == 2'h1 && stb_rise) begin
      nxt_rattr = ~a_s_n;
      nxt_rxs = 2'h2;
    end else if (rxs_ff == 2'h2 && bclk_edge) begin
      nxt_rvalid = 1'b1;
      nxt_rerr = (ap_s_n != exp_ap);
      nxt_rxs = 2'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stbp_ff <= STB_IDLE_N;
      rxs_ff <= 2'h0;
      raddr_ff <= '0;
      rattr_ff <= '0;
      rtype_ff <= '0;
      rvalid_ff <= 1'b0;
      rerr_ff <= 1'b0;
    end else begin
      stbp_ff <= stb_s_n;
      rxs_ff <= nxt_rxs;
      raddr_ff <= nxt_raddr;
      rattr_ff <= nxt_rattr;
      rtype_ff <= nxt_rtype;
      rvalid_ff <= nxt_rvalid;
      rerr_ff <= nxt_rerr;
    end
  end

  assign rx_valid = rvalid_ff;
  assign rx_addr = raddr_ff;
  assign rx_attr = rattr_ff;
  assign rx_type = rtype_ff;
  assign rx_parity_err = rerr_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_mask_bit_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_ff == FSBRQ_IDLE && tx_req && !mask_n_s) |=> !addr_ff[MASK_BIT-ADDR_LO])
    else $error("masked bit twenty not cleared");
  chk_parity_after_ads: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ($rose(ads_ff) && st_ff == FSBRQ_PAR) |-> !apoe_ff)
    else $error("parity not driven after strobe");
  chk_ads_with_oe: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !ads_ff |-> !aoe_ff)
    else $error("strobe without address drive");
  chk_tx_parity_val: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(apoe_ff) |-> ap_ff[0] == ~(^(addr_ff[ADDR_W-1 -: 16])))
    else $error("parity bit 0 coverage wrong");
  chk_only_on_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(ads_ff) |-> $past(bclk_edge))
    else $error("strobe moved off reference edge");
  chk_sub2_attr_lines: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ($rose(ads_ff) && st_ff == FSBRQ_PAR) |-> (aout_ff == ~attr_ff))
    else $error("second subphase lines do not carry request info");
endmodule : fsbrq_req_phase

/* File: rtl/fsbrq_sync.sv */
// Purpose: two flip-flop synchroniser, generic width
// Assumes: inputs asynchronous to ref_clk
// Notes: first stage feeds only the second

`timescale 1ns/1ps

module fsbrq_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk, // core clock
  input wire logic sys_rst, // sync reset, high
  input wire logic [W-1:0] async_in, // raw input
  output logic [W-1:0] sync_out // synchronised
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : fsbrq_sync
